// *** verilog/scsl_core.sv ***
// Contract
// RQ1 - raw frame and ptp modes only on socket 0
// RQ2 - command register self-clears after execution
// RQ3 - open moves state per protocol setting
// RQ4 - listen: tcp ready to awaiting peer
// RQ5 - dial sends request; failure raises timeout
// RQ6 - teardown sends end request; failure raises timeout
// RQ7 - close goes straight to idle
// RQ8 - send transmits the advanced write pointer amount
// RQ9 - fixed-hwaddr send for datagram, no resolution
// RQ10 - probe sends one byte; failure raises timeout
// RQ11 - receive done releases data via read pointer
// RQ12 - flags clear only by writing one
// RQ13 - bit 4 set on send completion
// RQ14 - bit 3 set on timeout
// RQ15 - bit 2 on data and leftover data
// RQ16 - bit 1 on termination, bit 0 connect
// RQ17 - idle after close, timeout or end
// RQ18 - tcp ready after open in tcp mode
// RQ19 - awaiting peer goes connected on request
// RQ20 - tcp data only while connected; the code also allows send and receive done in peer ending
// RQ21 - peer ending until teardown or close
// RQ22 - open gives datagram, raw and ptp codes
// RQ23 - invalid commands ignored but still cleared
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module scsl_core #(
   parameter int SOCKETS = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [SOCKETS-1:0][3:0] socket_protocol_setting,
   input wire scsl_pkg::scsl_evt_t [SOCKETS-1:0] net_evt,
   output scsl_pkg::scsl_job_t [SOCKETS-1:0] job
);
   localparam int SW = $clog2(SOCKETS);

   // apb decode: no wait state, yet every answer comes from a flop
   wire setup = psel & ~penable;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   wire wr_fire = psel & penable & pready_r & pwrite;
   wire [15:0] idx = paddr[17:2];
   wire [SW-1:0] idx_sock = idx[scsl_pkg::SCSL_SOCK_LSB +: SW];
   wire [7:0] idx_reg = idx[7:0];
   wire base_ok = (paddr[31:18] == 14'h0000) & (paddr[1:0] == 2'h0)
      & (idx[15:scsl_pkg::SCSL_BASE_LSB]
         == scsl_pkg::SCSL_CMD_IDX[15:scsl_pkg::SCSL_BASE_LSB])
      & ({1'b0, idx[scsl_pkg::SCSL_BASE_LSB-1:scsl_pkg::SCSL_SOCK_LSB]}
         < 3'(SOCKETS));
   wire is_cmd = idx_reg == scsl_pkg::SCSL_CMD_IDX[7:0];
   wire is_flag = idx_reg == scsl_pkg::SCSL_FLAG_IDX[7:0];
   wire is_state = idx_reg == scsl_pkg::SCSL_STATE_IDX[7:0];
   wire hit = base_ok & (is_cmd | is_flag | is_state);

   logic [SOCKETS-1:0][7:0] rd_cmd;
   logic [SOCKETS-1:0][7:0] rd_flags;
   logic [SOCKETS-1:0][7:0] rd_state;
   wire [7:0] rd_byte = is_cmd ? rd_cmd[idx_sock] :
      is_flag ? rd_flags[idx_sock] : rd_state[idx_sock];

   // bus answer flops; read data is captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~hit;
         if (setup & ~pwrite) begin
            prdata_r <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         end
      end
   end
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;

   genvar s;
   generate
      for (s = 0; s < SOCKETS; s++) begin : g_sock
         logic [7:0] cmd_r;
         logic [7:0] flags_r;
         logic [7:0] set_v;
         scsl_pkg::scsl_state_t st_r;
         scsl_pkg::scsl_state_t st_nxt;
         scsl_pkg::scsl_job_t job_r;
         scsl_pkg::scsl_job_t job_nxt;
         scsl_pkg::scsl_evt_t ev;
         logic [3:0] mode;

         assign ev = net_evt[s];
         assign mode = socket_protocol_setting[s];
         wire sel_s = wr_fire & hit & (idx_sock == SW'(s));
         wire cmd_wr = sel_s & is_cmd;
         wire [7:0] clr_v = (sel_s & is_flag) ? pwdata[7:0] : 8'h00;
         // extended modes exist on the first socket only
         wire ext_ok = (s == 0) &
            ((mode == scsl_pkg::SCSL_RAW_FRAME_MODE) |
             (mode == scsl_pkg::SCSL_PROTO_PTP)); // RQ1
         wire mode_ok = (mode == scsl_pkg::SCSL_PROTO_TCP) |
            (mode == scsl_pkg::SCSL_PROTO_DGRAM) |
            (mode == scsl_pkg::SCSL_RAW_IP_MODE) | ext_ok; // RQ1
         wire is_tcp = mode == scsl_pkg::SCSL_PROTO_TCP;
         wire tcp_live = (st_r == scsl_pkg::state_connected) |
            (st_r == scsl_pkg::state_peer_ending);
         // tcp data moves only once the connection is up
         wire can_xfer = (tcp_live & is_tcp) | // RQ20
            (st_r == scsl_pkg::state_datagram) |
            (st_r == scsl_pkg::state_raw_ip) |
            (st_r == scsl_pkg::state_raw_frame);

         // network events first, then a pending command overrides
         always_comb begin
            st_nxt = st_r;
            set_v = 8'h00;
            job_nxt = '0;
            unique case (st_r)
               scsl_pkg::state_awaiting_peer: begin
                  if (ev.peer_conn_req) begin
                     st_nxt = scsl_pkg::state_connected; // RQ19
                     set_v[scsl_pkg::SCSL_LINK_UP_FLAG] = 1'b1; // RQ16
                  end
               end
               scsl_pkg::state_dialing: begin
                  if (ev.dial_ok) begin
                     st_nxt = scsl_pkg::state_connected;
                     set_v[scsl_pkg::SCSL_LINK_UP_FLAG] = 1'b1; // RQ16
                  end else if (ev.dial_fail) begin
                     st_nxt = scsl_pkg::state_idle; // RQ17
                     set_v[scsl_pkg::SCSL_TIMEOUT_FLAG] = 1'b1; // RQ5
                  end
               end
               scsl_pkg::state_connected: begin
                  if (ev.peer_close_req) begin
                     st_nxt = scsl_pkg::state_peer_ending; // RQ21
                     set_v[scsl_pkg::SCSL_PEER_END_FLAG] = 1'b1; // RQ16
                  end
               end
               scsl_pkg::state_closing_local: begin
                  if (ev.teardown_ok) begin
                     st_nxt = scsl_pkg::state_idle; // RQ17
                     set_v[scsl_pkg::SCSL_PEER_END_FLAG] = 1'b1; // RQ16
                  end else if (ev.teardown_fail) begin
                     st_nxt = scsl_pkg::state_idle;
                     set_v[scsl_pkg::SCSL_TIMEOUT_FLAG] = 1'b1; // RQ6
                  end
               end
               default: ;
            endcase
            if (ev.send_ok) begin
               set_v[scsl_pkg::SCSL_SENT_FLAG] = 1'b1; // RQ13
            end
            if (ev.send_timeout) begin
               set_v[scsl_pkg::SCSL_TIMEOUT_FLAG] = 1'b1; // RQ14
               // a lost tcp link frees the socket
               if (tcp_live) begin
                  st_nxt = scsl_pkg::state_idle; // RQ17
               end
            end
            if (ev.rx_data | ev.rx_left) begin
               set_v[scsl_pkg::SCSL_RX_FLAG] = 1'b1; // RQ15
            end
            job_nxt.code = cmd_r;
            unique case (cmd_r)
               scsl_pkg::SCSL_CMD_OPEN: begin
                  job_nxt.go = mode_ok;
                  if (mode_ok) begin
                     unique case (mode)
                        scsl_pkg::SCSL_PROTO_TCP:
                           st_nxt = scsl_pkg::state_tcp_ready; // RQ18
                        scsl_pkg::SCSL_PROTO_DGRAM:
                           st_nxt = scsl_pkg::state_datagram; // RQ22
                        scsl_pkg::SCSL_RAW_IP_MODE:
                           st_nxt = scsl_pkg::state_raw_ip; // RQ22
                        scsl_pkg::SCSL_RAW_FRAME_MODE:
                           st_nxt = scsl_pkg::state_raw_frame; // RQ3
                        default:
                           st_nxt = scsl_pkg::state_ptp_over_ether;
                     endcase
                  end
               end
               scsl_pkg::SCSL_CMD_LISTEN: begin
                  if (is_tcp & (st_r == scsl_pkg::state_tcp_ready)) begin
                     st_nxt = scsl_pkg::state_awaiting_peer; // RQ4
                     job_nxt.go = 1'b1;
                  end
               end
               scsl_pkg::SCSL_CMD_DIAL: begin
                  if (is_tcp & (st_r == scsl_pkg::state_tcp_ready)) begin
                     st_nxt = scsl_pkg::state_dialing; // RQ5
                     job_nxt.go = 1'b1;
                  end
               end
               scsl_pkg::SCSL_TEARDOWN_CMD: begin
                  if (is_tcp & tcp_live) begin
                     st_nxt = scsl_pkg::state_closing_local; // RQ6
                     job_nxt.go = 1'b1;
                  end
               end
               scsl_pkg::SCSL_CMD_CLOSE: begin
                  // no exchange with the peer, engines just abort
                  st_nxt = scsl_pkg::state_idle; // RQ7
                  job_nxt.go = 1'b1;
               end
               scsl_pkg::SCSL_CMD_SEND: begin
                  // engine sends write minus read pointer bytes
                  job_nxt.go = can_xfer; // RQ8
               end
               scsl_pkg::SCSL_SEND_FIXED_HWADDR_CMD: begin
                  job_nxt.go = st_r == scsl_pkg::state_datagram; // RQ9
               end
               scsl_pkg::SCSL_CMD_PROBE: begin
                  job_nxt.go = is_tcp &
                     (st_r == scsl_pkg::state_connected); // RQ10
               end
               scsl_pkg::SCSL_RECEIVE_DONE_CMD: begin
                  job_nxt.go = can_xfer; // RQ11
               end
               default: ; // RQ23
            endcase
         end

         // a write to the command register wins over the self-clear
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cmd_r <= scsl_pkg::SCSL_CMD_RST;
               flags_r <= scsl_pkg::SCSL_FLAG_RST;
               st_r <= scsl_pkg::state_idle;
               job_r <= '0;
            end else begin
               cmd_r <= cmd_wr ? pwdata[7:0] : scsl_pkg::SCSL_CMD_NONE; // RQ2
               flags_r <= (flags_r & ~clr_v) | set_v; // RQ12
               st_r <= st_nxt;
               job_r <= job_nxt;
            end
         end

         assign rd_cmd[s] = cmd_r;
         assign rd_flags[s] = flags_r;
         assign rd_state[s] = st_r;
         assign job[s] = job_r;
      end
   endgenerate
endmodule // scsl_core

// *** include/scsl_pkg.sv ***
package scsl_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] SCSL_CMD_IDX = 16'h0401;
   localparam logic [15:0] SCSL_FLAG_IDX = 16'h0402;
   localparam logic [15:0] SCSL_STATE_IDX = 16'h0403;
   localparam logic [15:0] SCSL_STRIDE_IDX = 16'h0100;
   localparam int SCSL_SOCK_LSB = 8;
   localparam int SCSL_BASE_LSB = 10;
   // reset values
   localparam logic [7:0] SCSL_CMD_RST = 8'h00;
   localparam logic [7:0] SCSL_FLAG_RST = 8'h00;
   // command codes
   localparam logic [7:0] SCSL_CMD_NONE = 8'h00;
   localparam logic [7:0] SCSL_CMD_OPEN = 8'h01;
   localparam logic [7:0] SCSL_CMD_LISTEN = 8'h02;
   localparam logic [7:0] SCSL_CMD_DIAL = 8'h04;
   localparam logic [7:0] SCSL_TEARDOWN_CMD = 8'h08;
   localparam logic [7:0] SCSL_CMD_CLOSE = 8'h10;
   localparam logic [7:0] SCSL_CMD_SEND = 8'h20;
   localparam logic [7:0] SCSL_SEND_FIXED_HWADDR_CMD = 8'h21;
   localparam logic [7:0] SCSL_CMD_PROBE = 8'h22;
   localparam logic [7:0] SCSL_RECEIVE_DONE_CMD = 8'h40;
   // event flag bit positions
   localparam int SCSL_LINK_UP_FLAG = 0;
   localparam int SCSL_PEER_END_FLAG = 1;
   localparam int SCSL_RX_FLAG = 2;
   localparam int SCSL_TIMEOUT_FLAG = 3;
   localparam int SCSL_SENT_FLAG = 4;
   // protocol field settings
   localparam logic [3:0] SCSL_PROTO_TCP = 4'h1;
   localparam logic [3:0] SCSL_PROTO_DGRAM = 4'h2;
   localparam logic [3:0] SCSL_RAW_IP_MODE = 4'h3;
   localparam logic [3:0] SCSL_RAW_FRAME_MODE = 4'h4;
   localparam logic [3:0] SCSL_PROTO_PTP = 4'h5;

   typedef enum logic [7:0] {
      state_idle = 8'h00,
      state_tcp_ready = 8'h13,
      state_awaiting_peer = 8'h14,
      state_dialing = 8'h15,
      state_connected = 8'h17,
      state_closing_local = 8'h18,
      state_peer_ending = 8'h1C,
      state_datagram = 8'h22,
      state_raw_ip = 8'h32,
      state_raw_frame = 8'h42,
      state_ptp_over_ether = 8'h5F
   } scsl_state_t;

   // one-cycle pulses from the network engines of one socket
   typedef struct packed {
      logic peer_conn_req;
      logic dial_ok;
      logic dial_fail;
      logic peer_close_req;
      logic teardown_ok;
      logic teardown_fail;
      logic send_ok;
      logic send_timeout;
      logic rx_data;
      logic rx_left;
   } scsl_evt_t;

   // command handed to the engines of one socket
   typedef struct packed {
      logic go;
      logic [7:0] code;
   } scsl_job_t;
endpackage

// *** sim/scsl_monitor.sv ***
`timescale 1ns/1ps
module scsl_monitor #(
   parameter int SOCKETS = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [SOCKETS-1:0][3:0] socket_protocol_setting,
   input wire scsl_pkg::scsl_evt_t [SOCKETS-1:0] net_evt,
   input wire scsl_pkg::scsl_job_t [SOCKETS-1:0] job
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // completed accesses to socket 0 registers
   wire acc = psel && penable && pready;
   wire wr_cmd = acc && pwrite && paddr == 32'h0000_1004;
   wire rd_cmd = acc && !pwrite && paddr == 32'h0000_1004;
   wire wr_flag = acc && pwrite && paddr == 32'h0000_1008;
   wire rd_flag = acc && !pwrite && paddr == 32'h0000_1008;
   wire rd_state = acc && !pwrite && paddr == 32'h0000_100C;
   // flags 4:2 that must be up; a lower bound only, set beats clear
   logic [2:0] pend_r;
   wire [2:0] pend_nxt = (pend_r & ~({3{wr_flag}} & pwdata[4:2]))
      | {net_evt[0].send_ok, net_evt[0].send_timeout,
         net_evt[0].rx_data | net_evt[0].rx_left};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pend_r <= 3'h0;
      else pend_r <= pend_nxt;
   end
   job_after_cmd_a: assert property (job[0].go |->
      $past(wr_cmd, 2) && job[0].code == $past(pwdata[7:0], 2))
      else $error("job without matching command write");
   valid_code_a: assert property (job[0].go |->
      job[0].code inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
      8'h21, 8'h22, 8'h40}) else $error("job with undefined code");
   raw_only_s0_a: assert property (
      job[1].go && job[1].code == 8'h01
      |-> socket_protocol_setting[1] inside {4'h1, 4'h2, 4'h3})
      else $error("open on socket 1 in socket 0 only mode");
   cmd_clear_a: assert property (rd_cmd && !$past(wr_cmd)
      && !$past(wr_cmd, 2) && !$past(wr_cmd, 3) |-> prdata[7:0] == 8'h00)
      else $error("command register not cleared");
   state_code_a: assert property (rd_state |-> prdata[7:0] inside
      {8'h00, 8'h13, 8'h14, 8'h15, 8'h17, 8'h18, 8'h1C, 8'h22, 8'h32,
      8'h42, 8'h5F}) else $error("state code out of set");
   rx_flag_a: assert property (
      rd_flag && $past(pend_r[0]) |-> prdata[2])
      else $error("receive flag lost");
   tout_flag_a: assert property (
      rd_flag && $past(pend_r[1]) |-> prdata[3])
      else $error("timeout flag lost");
   sent_flag_a: assert property (
      rd_flag && $past(pend_r[2]) |-> prdata[4])
      else $error("sent flag lost");
endmodule // scsl_monitor

// *** sim/scsl_engine.sv ***
`timescale 1ns/1ps
module scsl_engine #(
   parameter int SOCKETS = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire scsl_pkg::scsl_job_t [SOCKETS-1:0] job,
   input wire scsl_pkg::scsl_evt_t kick,
   output scsl_pkg::scsl_evt_t [SOCKETS-1:0] net_evt
);
   // send-type jobs finish a cycle later; scripted pulses on socket 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         net_evt <= '0;
      end else begin
         net_evt <= '0;
         net_evt[0] <= kick;
         for (int s = 0; s < SOCKETS; s++) begin
            if (job[s].go && job[s].code[7:5] == 3'h1) begin
               net_evt[s].send_ok <= 1'b1;
            end
         end
      end
   end
endmodule // scsl_engine

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] CMD = 32'h0000_1004;
   localparam logic [31:0] FLG = 32'h0000_1008;
   localparam logic [31:0] STA = 32'h0000_100C;
   localparam logic [31:0] S1 = 32'h0000_0400;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0][3:0] proto = 16'h0000;
   scsl_pkg::scsl_evt_t kick = '0;
   scsl_pkg::scsl_evt_t [3:0] net_evt;
   scsl_pkg::scsl_job_t [3:0] job;
   int num_errors = 0;
   int n_tests = 0;
   scsl_core #(.SOCKETS(4)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .socket_protocol_setting(proto),
      .net_evt(net_evt), .job(job));
   scsl_engine #(.SOCKETS(4)) eng (.pclk(pclk), .presetn(presetn),
      .job(job), .kick(kick), .net_evt(net_evt));
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
         num_errors++;
      end
   endtask
   // one apb transfer; waits on pready, bounded
   task automatic apb(logic w, logic [31:0] a, logic [31:0] d,
      logic [7:0] exp, logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         num_errors++;
         stop_test();
      end
      if (!w && !err) chk("read data", {24'h000000, exp}, prdata);
      chk("error response", {31'h0, err}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(logic [31:0] a, logic [7:0] d);
      apb(1'b1, a, {24'h000000, d}, 8'h00, 1'b0);
   endtask
   task automatic rd(logic [31:0] a, logic [7:0] exp);
      apb(1'b0, a, 32'h0000_0000, exp, 1'b0);
   endtask
   // command plus time for job and engine answer to land
   task automatic cmd(logic [31:0] a, logic [7:0] c);
      wr(a, c);
      repeat (3) @(posedge pclk);
   endtask
   // bit b of the event struct, 0 = rx_left up to 9 = peer_conn_req
   task automatic pulse(int b);
      kick <= scsl_pkg::scsl_evt_t'(10'h001 << b);
      @(posedge pclk);
      kick <= '0;
      repeat (2) @(posedge pclk);
   endtask
   task automatic t_regs();
      rd(CMD, 8'h00);
      rd(FLG, 8'h00);
      wr(STA, 8'h17);
      rd(STA, 8'h00);
      apb(1'b0, 32'h0000_0000, 32'h0000_0000, 8'h00, 1'b1);
   endtask
   task automatic t_modes();
      logic [3:0] md [4] = '{4'h2, 4'h3, 4'h4, 4'h5};
      logic [7:0] st [4] = '{8'h22, 8'h32, 8'h42, 8'h5F};
      for (int i = 0; i < 4; i++) begin
         proto[0] <= md[i];
         cmd(CMD, scsl_pkg::SCSL_CMD_OPEN);
         rd(STA, st[i]);
         rd(CMD, 8'h00);
         cmd(CMD, scsl_pkg::SCSL_SEND_FIXED_HWADDR_CMD);
         rd(FLG, (i == 0) ? 8'h10 : 8'h00);
         wr(FLG, 8'h1F);
         proto[1] <= md[i];
         cmd(CMD + S1, scsl_pkg::SCSL_CMD_OPEN);
         // a refused open leaves the raw ip state of the pass before
         rd(STA + S1, (i < 2) ? st[i] : 8'h32);
      end
   endtask
   task automatic t_server();
      proto[0] <= scsl_pkg::SCSL_PROTO_TCP;
      cmd(CMD, scsl_pkg::SCSL_CMD_OPEN);
      rd(STA, 8'h13);
      cmd(CMD, scsl_pkg::SCSL_CMD_LISTEN);
      rd(STA, 8'h14);
      pulse(9);
      rd(STA, 8'h17);
      rd(FLG, 8'h01);
      cmd(CMD, scsl_pkg::SCSL_CMD_SEND);
      pulse(1);
      rd(FLG, 8'h15);
      wr(FLG, 8'h01);
      rd(FLG, 8'h14);
      wr(FLG, 8'h1F);
      cmd(CMD, scsl_pkg::SCSL_RECEIVE_DONE_CMD);
      pulse(0);
      rd(FLG, 8'h04);
      pulse(6);
      rd(STA, 8'h1C);
      cmd(CMD, scsl_pkg::SCSL_CMD_PROBE);
      rd(FLG, 8'h06);
      cmd(CMD, scsl_pkg::SCSL_TEARDOWN_CMD);
      rd(STA, 8'h18);
      pulse(4);
      rd(STA, 8'h00);
      rd(FLG, 8'h0E);
   endtask
   task automatic t_client();
      wr(FLG, 8'h1F);
      cmd(CMD, scsl_pkg::SCSL_CMD_OPEN);
      cmd(CMD, scsl_pkg::SCSL_CMD_DIAL);
      rd(STA, 8'h15);
      pulse(7);
      rd(STA, 8'h00);
      cmd(CMD, scsl_pkg::SCSL_CMD_OPEN);
      cmd(CMD, scsl_pkg::SCSL_CMD_DIAL);
      pulse(8);
      cmd(CMD, scsl_pkg::SCSL_CMD_PROBE);
      rd(FLG, 8'h19);
      cmd(CMD, scsl_pkg::SCSL_CMD_CLOSE);
      rd(STA, 8'h00);
      wr(FLG, 8'h1F);
      cmd(CMD, scsl_pkg::SCSL_CMD_OPEN);
      cmd(CMD, scsl_pkg::SCSL_CMD_DIAL);
      pulse(8);
      // undefined code: no state change, no flag
      cmd(CMD, 8'h7F);
      rd(STA, 8'h17);
      rd(FLG, 8'h01);
      cmd(CMD, scsl_pkg::SCSL_TEARDOWN_CMD);
      pulse(5);
      rd(STA, 8'h00);
      rd(FLG, 8'h03);
      cmd(CMD, scsl_pkg::SCSL_CMD_OPEN);
      cmd(CMD, scsl_pkg::SCSL_CMD_DIAL);
      pulse(8);
      wr(FLG, 8'h1F);
      // send timeout on a live link frees the socket
      pulse(2);
      rd(STA, 8'h00);
      rd(FLG, 8'h08);
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_modes();
      t_server();
      t_client();
      stop_test();
   end
endmodule // tb
bind scsl_core scsl_monitor #(.SOCKETS(SOCKETS)) mon (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .socket_protocol_setting(socket_protocol_setting),
   .net_evt(net_evt), .job(job));
